// ---- verilog/tcpwm_top.sv ----
// Three-phase complementary PWM generator with dead time and an APB register port.
// Assumes an APB master on mclk_i and gate drivers that tolerate released pins.
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_regs.svh"

module tcpwm_top
    import tcpwm_pkg::*;
#(
    parameter logic [13:0] CARRIER_HALF = 14'(`TCPWM_CARRIER_HALF)
)
(
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    output logic      [2:0]  pwm_pos_o,
    output logic      [2:0]  pwm_neg_o,
    output logic      [2:0]  pwm_pos_oe_o,
    output logic      [2:0]  pwm_neg_oe_o
);

    localparam logic [13:0] DEAD_CYC = 14'(`TCPWM_DEAD_CYC);

    // Bus and register state
    tcpwm_ctrl_t             ctrl_reg;
    tcpwm_ctrl_t             ctrl_next;
    logic [`TCPWM_ST_W-1:0]  status_reg;
    logic [`TCPWM_ST_W-1:0]  status_next;
    logic [`TCPWM_ST_W-1:0]  mask_reg;
    logic [`TCPWM_ST_W-1:0]  mask_next;
    logic [13:0]             buffer_reg;
    logic [13:0]             buffer_next;
    logic [13:0]             gra_reg;
    logic [13:0]             gra_next;
    logic                    ready_reg;
    logic                    ready_next;
    logic                    err_reg;
    logic                    err_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic                    irq_reg;
    logic                    irq_next;

    // Counter and compare state
    logic [13:0]             count_reg;
    logic [13:0]             count_next;
    logic                    up_reg;
    logic                    up_next;
    logic [13:0]             compare_reg;
    logic [13:0]             compare_next;
    logic [13:0]             temp_reg;
    logic [13:0]             temp_next;
    logic                    raw_reg;
    logic                    raw_next;
    tcpwm_interval_t         interval;

    // Pin state
    tcpwm_phase_t            pins_reg;
    tcpwm_phase_t            pins_next;
    logic                    oe_reg;
    logic                    oe_next;
    logic [2:0]              pos_active;
    logic [2:0]              neg_active;

    logic                    access;
    logic                    mapped;
    logic                    gra_hit;
    logic                    trough;
    logic                    on_match;
    logic                    off_match;

    assign access = psel_i && penable_i && ready_reg;
    assign trough = ctrl_reg.run && (count_reg == 14'h0000);
    assign gra_hit = ctrl_reg.run && (count_reg == gra_reg);

    always_comb
    begin
        unique case (paddr_i)
            `TCPWM_OFS_CTRL,
            `TCPWM_OFS_STATUS,
            `TCPWM_OFS_MASK,
            `TCPWM_OFS_BUFFER,
            `TCPWM_OFS_GRA,
            `TCPWM_OFS_COMPARE,
            `TCPWM_OFS_TEMP,
            `TCPWM_OFS_COUNT: mapped = 1'b1;
            default:          mapped = 1'b0;
        endcase
    end

    // One wait state so that read data and the answer come from flip-flops
    always_comb
    begin
        ctrl_next   = ctrl_reg;
        mask_next   = mask_reg;
        buffer_next = buffer_reg;
        gra_next    = gra_reg;
        ready_next  = psel_i && penable_i && !ready_reg;
        err_next    = psel_i && penable_i && !ready_reg && !mapped;
        rdata_next  = 32'h0000_0000;
        status_next = status_reg;
        if (psel_i && penable_i && !ready_reg && !pwrite_i)
        begin
            unique case (paddr_i)
                `TCPWM_OFS_CTRL:    rdata_next = {30'h0, ctrl_reg};
                `TCPWM_OFS_STATUS:  rdata_next = {30'h0, status_reg};
                `TCPWM_OFS_MASK:    rdata_next = {30'h0, mask_reg};
                `TCPWM_OFS_BUFFER:  rdata_next = {18'h0, buffer_reg};
                `TCPWM_OFS_GRA:     rdata_next = {18'h0, gra_reg};
                `TCPWM_OFS_COMPARE: rdata_next = {18'h0, compare_reg};
                `TCPWM_OFS_TEMP:    rdata_next = {18'h0, temp_reg};
                `TCPWM_OFS_COUNT:   rdata_next = {16'h0, interval == TCPWM_IVL_SECOND,
                                                  up_reg, count_reg};
                default:            rdata_next = 32'h0000_0000;
            endcase
        end
        if (access && pwrite_i && mapped)
        begin
            unique case (paddr_i)
                `TCPWM_OFS_CTRL:   ctrl_next   = pwdata_i[1:0];
                `TCPWM_OFS_MASK:   mask_next   = pwdata_i[`TCPWM_ST_W-1:0];
                `TCPWM_OFS_BUFFER: buffer_next = pwdata_i[13:0];
                `TCPWM_OFS_GRA:    gra_next    = pwdata_i[13:0];
                default:           ctrl_next   = ctrl_reg;
            endcase
        end
        // Read clears only what was reported, so an event during the wait state survives
        if (access && !pwrite_i && (paddr_i == `TCPWM_OFS_STATUS))
        begin
            status_next = status_reg & ~rdata_reg[`TCPWM_ST_W-1:0];
        end
        if (gra_hit)
        begin
            status_next[`TCPWM_ST_GRA] = 1'b1;
        end
        if (trough)
        begin
            status_next[`TCPWM_ST_TROUGH] = 1'b1;
        end
        irq_next = |(status_next & mask_reg);
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_reg   <= `TCPWM_CTRL_RESET;
            status_reg <= '0;
            mask_reg   <= '0;
            buffer_reg <= 14'h0000;
            gra_reg    <= CARRIER_HALF;
            ready_reg  <= 1'b0;
            err_reg    <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            irq_reg    <= 1'b0;
        end
        else
        begin
            ctrl_reg   <= ctrl_next;
            status_reg <= status_next;
            mask_reg   <= mask_next;
            buffer_reg <= buffer_next;
            gra_reg    <= gra_next;
            ready_reg  <= ready_next;
            err_reg    <= err_next;
            rdata_reg  <= rdata_next;
            irq_reg    <= irq_next;
        end
    end

    // Update interval straddles the trough, one dead time each side
    always_comb
    begin
        if (count_reg < DEAD_CYC)
        begin
            interval = TCPWM_IVL_UPDATE;
        end
        else if (up_reg)
        begin
            interval = TCPWM_IVL_FIRST;
        end
        else
        begin
            interval = TCPWM_IVL_SECOND;
        end
    end

    always_comb
    begin
        count_next   = count_reg;
        up_next      = up_reg;
        compare_next = compare_reg;
        temp_next    = temp_reg;
        raw_next     = raw_reg;
        on_match     = 1'b0;
        off_match    = 1'b0;
        if (!ctrl_reg.run)
        begin
            count_next = 14'h0000;
            up_next    = 1'b1;
            raw_next   = 1'b0;
        end
        else
        begin
            // Triangle: 0 up to the peak and back, one carrier per round trip
            count_next = up_reg ? count_reg + 14'h0001 : count_reg - 14'h0001;
            if (up_reg && (count_next == CARRIER_HALF))
            begin
                up_next = 1'b0;
            end
            else if (!up_reg && (count_next == 14'h0000))
            begin
                up_next = 1'b1;
            end
            unique case (interval)
                TCPWM_IVL_UPDATE:
                begin
                    temp_next = buffer_reg;
                    on_match  = up_reg && (count_reg == compare_reg);
                    off_match = !up_reg && (count_reg == compare_reg);
                end
                TCPWM_IVL_FIRST:
                begin
                    on_match = (count_reg == compare_reg) || (count_reg == temp_reg);
                end
                TCPWM_IVL_SECOND:
                begin
                    off_match = (count_reg == compare_reg) || (count_reg == temp_reg);
                    // Transfer point of the second complementary variant: trough side only
                    if (count_next < DEAD_CYC)
                    begin
                        compare_next = temp_reg;
                    end
                end
            endcase
            // Each carrier opens from a defined level so 0 and full scale hold exactly
            if (trough)
            begin
                on_match  = (compare_reg == 14'h0000);
                off_match = (compare_reg != 14'h0000);
            end
            if (on_match && !off_match)
            begin
                raw_next = 1'b1;
            end
            else if (off_match && !on_match)
            begin
                raw_next = 1'b0;
            end
            // Both at once: level left unchanged
            else
            begin
                raw_next = raw_reg;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_reg   <= 14'h0000;
            up_reg      <= 1'b1;
            compare_reg <= CARRIER_HALF;
            temp_reg    <= CARRIER_HALF;
            raw_reg     <= 1'b0;
        end
        else
        begin
            count_reg   <= count_next;
            up_reg      <= up_next;
            compare_reg <= compare_next;
            temp_reg    <= temp_next;
            raw_reg     <= raw_next;
        end
    end

    // One shared raw level keeps all phases on the same duty
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++)
        begin : g_phase
            tcpwm_deadtime u_dead
            (
                .mclk_i       (mclk_i),
                .reset_n_i    (reset_n_i),
                .enable_i     (ctrl_reg.run),
                .raw_i        (raw_reg),
                .pos_active_o (pos_active[ph]),
                .neg_active_o (neg_active[ph])
            );
        end
    endgenerate

    always_comb
    begin
        pins_next.pos = ~pos_active;
        pins_next.neg = ~neg_active;
        oe_next       = !ctrl_reg.protect;
    end

    // Protect is set from reset so pins stay released until software says otherwise
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pins_reg <= '1;
            oe_reg   <= 1'b0;
        end
        else
        begin
            pins_reg <= pins_next;
            oe_reg   <= oe_next;
        end
    end

    assign prdata_o     = rdata_reg;
    assign pready_o     = ready_reg;
    assign pslverr_o    = err_reg;
    assign irq_o        = irq_reg;
    assign pwm_pos_o    = pins_reg.pos;
    assign pwm_neg_o    = pins_reg.neg;
    assign pwm_pos_oe_o = {3{oe_reg}};
    assign pwm_neg_oe_o = {3{oe_reg}};

endmodule // tcpwm_top

`default_nettype wire

// ---- verilog/tcpwm_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the PWM block.
// Assumes a 10 MHz clock and APB byte addressing with one 32-bit word per register.
// What this block does
// - Edges come from counter matching compare or temporary
// - Update interval: temporary stages, compare alone shapes
// - Compare intervals: both registers produce edges
// - First-edge matches switch negative phase off
// - Down-count closing match switches negative back on
// - Duty follows compare: 0 gives 100%, the peak gives 0%
// - Complementary mode two, channels three and four
// - All PWM outputs active low
// - Thirty microsecond dead time between complementary outputs
// - Carrier period is one millisecond
// - Three phases share identical duty settings
// - Pins high impedance while pin function changes
// - Buffer to temporary, temporary to compare timing
// - Simultaneous on and off matches are ignored
// - Start with both off, negative after dead time
// - Interrupt on general register A match
`ifndef TCPWM_REGS_SVH
`define TCPWM_REGS_SVH

`define TCPWM_CLK_HZ         10000000
`define TCPWM_CLK_PERIOD_NS  (1000000000 / `TCPWM_CLK_HZ)
`define TCPWM_CARRIER_NS     1000000
`define TCPWM_CARRIER_CYC    (`TCPWM_CARRIER_NS / `TCPWM_CLK_PERIOD_NS)
`define TCPWM_CARRIER_HALF   (`TCPWM_CARRIER_CYC / 2)
`define TCPWM_DEAD_NS        30000
`define TCPWM_DEAD_CYC       ((`TCPWM_DEAD_NS + `TCPWM_CLK_PERIOD_NS - 1) / `TCPWM_CLK_PERIOD_NS)

`define TCPWM_CNT_W          14
`define TCPWM_ADDR_W         8

`define TCPWM_OFS_CTRL       8'h00
`define TCPWM_OFS_STATUS     8'h04
`define TCPWM_OFS_MASK       8'h08
`define TCPWM_OFS_BUFFER     8'h0c
`define TCPWM_OFS_GRA        8'h10
`define TCPWM_OFS_COMPARE    8'h14
`define TCPWM_OFS_TEMP       8'h18
`define TCPWM_OFS_COUNT      8'h1c

`define TCPWM_CTRL_RUN       0
`define TCPWM_CTRL_PROTECT   1
`define TCPWM_CTRL_RESET     2'h2

`define TCPWM_ST_GRA         0
`define TCPWM_ST_TROUGH      1
`define TCPWM_ST_W           2

`define TCPWM_COUNT_DIR      14
`define TCPWM_COUNT_IVL      15

`endif

// ---- verilog/tcpwm_pkg.sv ----
// Types shared by the PWM block files.
// Assumes tcpwm_regs.svh is on the include path.
`include "tcpwm_regs.svh"

package tcpwm_pkg;

    typedef enum logic [1:0]
    {
        TCPWM_IVL_UPDATE = 2'h0,
        TCPWM_IVL_FIRST  = 2'h1,
        TCPWM_IVL_SECOND = 2'h3
    } tcpwm_interval_t;

    typedef struct packed
    {
        logic protect;
        logic run;
    } tcpwm_ctrl_t;

    typedef struct packed
    {
        logic [2:0] pos;
        logic [2:0] neg;
    } tcpwm_phase_t;

endpackage

// ---- verilog/tcpwm_deadtime.sv ----
// Dead-time shaper for one phase: turns one raw level into two complementary actives.
// Assumes the raw level and enable come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_regs.svh"

module tcpwm_deadtime
    import tcpwm_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    input  wire logic enable_i,
    input  wire logic raw_i,
    output logic      pos_active_o,
    output logic      neg_active_o
);

    localparam logic [8:0] DEAD_CYC = 9'(`TCPWM_DEAD_CYC);

    logic       last_reg;
    logic       last_next;
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic       pos_reg;
    logic       pos_next;
    logic       neg_reg;
    logic       neg_next;

    always_comb
    begin
        last_next = last_reg;
        cnt_next  = cnt_reg;
        pos_next  = pos_reg;
        neg_next  = neg_reg;
        if (!enable_i)
        begin
            // Both off while stopped, so a start always waits a full dead time
            last_next = 1'b0;
            cnt_next  = 9'h000;
            pos_next  = 1'b0;
            neg_next  = 1'b0;
        end
        else if (raw_i != last_reg)
        begin
            last_next = raw_i;
            cnt_next  = 9'h000;
            pos_next  = 1'b0;
            neg_next  = 1'b0;
        end
        else if (cnt_reg < DEAD_CYC)
        begin
            cnt_next = cnt_reg + 9'h001;
            if (cnt_next == DEAD_CYC)
            begin
                pos_next = last_reg;
                neg_next = !last_reg;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            last_reg <= 1'b0;
            cnt_reg  <= 9'h000;
            pos_reg  <= 1'b0;
            neg_reg  <= 1'b0;
        end
        else
        begin
            last_reg <= last_next;
            cnt_reg  <= cnt_next;
            pos_reg  <= pos_next;
            neg_reg  <= neg_next;
        end
    end

    assign pos_active_o = pos_reg;
    assign neg_active_o = neg_reg;

endmodule // tcpwm_deadtime

`default_nettype wire

// ---- verif/tcpwm_monitor.sv ----
// Port checker for the PWM block, bound into tcpwm_top.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_regs.svh"

module tcpwm_monitor
    import tcpwm_pkg::*;
#(
    parameter logic [13:0] CARRIER_HALF = 14'(`TCPWM_CARRIER_HALF)
)
(
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        irq_o,
    input wire logic [2:0]  pwm_pos_o,
    input wire logic [2:0]  pwm_neg_o,
    input wire logic [2:0]  pwm_pos_oe_o,
    input wire logic [2:0]  pwm_neg_oe_o
);
    // One cycle of slack for the pin register behind the shaper
    localparam int DEAD_MIN = `TCPWM_DEAD_CYC - 1;
    logic [11:0] off_reg;
    logic [11:0] off_next;

    always_comb
    begin
        off_next = 12'h000;
        if (pwm_pos_o[0] && pwm_neg_o[0])
            off_next = (off_reg == 12'hfff) ? off_reg : off_reg + 12'h001;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            off_reg <= 12'h000;
        else
            off_reg <= off_next;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    chk_no_overlap: assert property ((~pwm_pos_o & ~pwm_neg_o) == 3'h0)
        else $error("Both sides of a phase on");
    chk_dead_neg: assert property ($fell(pwm_neg_o[0]) |-> off_reg >= DEAD_MIN)
        else $error("Negative side on before dead time");
    chk_dead_pos: assert property ($fell(pwm_pos_o[0]) |-> off_reg >= DEAD_MIN)
        else $error("Positive side on before dead time");
    chk_phases_same: assert property (pwm_pos_o inside {3'h0, 3'h7} && pwm_neg_o inside {3'h0, 3'h7})
        else $error("Phases differ");
    chk_oe_same: assert property (pwm_pos_oe_o == pwm_neg_oe_o && pwm_pos_oe_o inside {3'h0, 3'h7})
        else $error("Output enables differ");
    chk_start_off: assert property ($rose(reset_n_i) |-> pwm_pos_oe_o == 3'h0 && pwm_pos_o == 3'h7)
        else $error("Pins not released and off after reset");
    chk_ready_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
        else $error("Answer not in second access cycle");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("Ready longer than one cycle");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("Error without ready");
    chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("Read data outside answer");

    cover property (pready_o && pslverr_o);
    cover property ($rose(irq_o));
    cover property ($fell(pwm_pos_o[0]));
endmodule // tcpwm_monitor

bind tcpwm_top tcpwm_monitor #(.CARRIER_HALF(CARRIER_HALF)) u_mon (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .pwm_pos_o(pwm_pos_o),
    .pwm_neg_o(pwm_neg_o), .pwm_pos_oe_o(pwm_pos_oe_o), .pwm_neg_oe_o(pwm_neg_oe_o));

`default_nettype wire

// ---- verif/tcpwm_gate_model.sv ----
// Gate driver model for the six PWM pins.
// Assumes pull-ups on the pins, so a released pin reads as off.
`timescale 1ns/100ps
`default_nettype none

module tcpwm_gate_model
(
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic [2:0] pos_pin_i,
    input wire logic [2:0] neg_pin_i,
    input wire logic [2:0] pos_oe_i,
    input wire logic [2:0] neg_oe_i,
    output logic     [2:0] hs_on_o,
    output logic     [2:0] ls_on_o,
    output logic           fault_o
);
    assign hs_on_o = ~((pos_pin_i & pos_oe_i) | ~pos_oe_i);
    assign ls_on_o = ~((neg_pin_i & neg_oe_i) | ~neg_oe_i);

    // Sticky, so a one-cycle overlap is not lost
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            fault_o <= 1'b0;
        else if (|(hs_on_o & ls_on_o))
            fault_o <= 1'b1;
    end
endmodule // tcpwm_gate_model

`default_nettype wire

// ---- verif/test_tcpwm_top.sv ----
// Self-checking bench for the PWM block over APB.
// Assumes the gate model on the pins and a shortened carrier.
`timescale 1ns/100ps
`default_nettype none
`include "tcpwm_regs.svh"

module test_tcpwm_top;
    import tcpwm_pkg::*;
    localparam int HALF = 400;
    logic        mclk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, irq, fault, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0]  pos, neg, pos_oe, neg_oe, hs_on, ls_on;
    int          mismatches, checked, wn, pon, non;
    longint      t0;

    tcpwm_top #(.CARRIER_HALF(14'(HALF))) dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq), .pwm_pos_o(pos), .pwm_neg_o(neg), .pwm_pos_oe_o(pos_oe),
        .pwm_neg_oe_o(neg_oe));
    tcpwm_gate_model u_gate (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .pos_pin_i(pos),
        .neg_pin_i(neg), .pos_oe_i(pos_oe), .neg_oe_i(neg_oe), .hs_on_o(hs_on),
        .ls_on_o(ls_on), .fault_o(fault));

    always #50 mclk_i = ~mclk_i;

    task end_of_test;
        $display("Checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task ran_out;
        mismatches++;
        $display("Error at %0t: wait ran out", $time);
        end_of_test;
    endtask

    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge mclk_i);
            n++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
            ran_out;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
        chk({31'h0, rerr}, 32'h0);
    endtask

    // Which: 0 interrupt, 1 positive pin, 2 negative pin
    task wait_for(input int lim, input int which, input logic lvl);
        wn = 0;
        while (wn < lim && (which == 0 ? irq : which == 1 ? pos[0] : neg[0]) !== lvl)
        begin
            @(posedge mclk_i);
            wn++;
        end
        if (wn == lim)
            ran_out;
    endtask

    task meas(input int n);
        pon = 0;
        non = 0;
        repeat (n)
        begin
            @(posedge mclk_i);
            pon += int'(hs_on[0]);
            non += int'(ls_on[0]);
        end
    endtask

    initial
    begin
        {mclk_i, reset_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
        mismatches = 0;
        checked = 0;
        repeat (12) @(posedge mclk_i);
        chk({26'h0, pos_oe, neg_oe}, 32'h0);
        chk({26'h0, pos, neg}, 32'h3f);
        reset_n_i <= 1'b1;
        rd(`TCPWM_OFS_CTRL, 32'h2);
        rd(`TCPWM_OFS_MASK, 32'h0);
        rd(`TCPWM_OFS_GRA, 32'(HALF));
        rd(`TCPWM_OFS_COMPARE, 32'(HALF));
        xfer(1'b1, `TCPWM_OFS_COMPARE, 32'h5);
        rd(`TCPWM_OFS_COMPARE, 32'(HALF));
        xfer(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // Staging the peak keeps every carrier at zero duty until software changes it
        xfer(1'b1, `TCPWM_OFS_BUFFER, 32'(HALF));
        xfer(1'b1, `TCPWM_OFS_CTRL, 32'h1);
        chk({26'h0, pos, neg}, 32'h3f);
        wait_for(400, 2, 1'b0);
        chk(32'(wn >= 300 && wn <= 305), 32'h1);
        chk({29'h0, pos_oe}, 32'h7);
        meas(2 * HALF);
        chk(pon, 0);
        chk(non, 2 * HALF);
        xfer(1'b0, `TCPWM_OFS_COUNT, 32'h0);
        chk(32'(rdat[13:0] <= 14'(HALF)), 32'h1);
        // Stale matches from the first carriers would raise the interrupt off the peak
        xfer(1'b0, `TCPWM_OFS_STATUS, 32'h0);
        xfer(1'b1, `TCPWM_OFS_MASK, 32'h1);
        wait_for(3 * HALF, 0, 1'b1);
        t0 = $time;
        xfer(1'b0, `TCPWM_OFS_STATUS, 32'h0);
        chk(rdat & 32'h1, 32'h1);
        xfer(1'b0, `TCPWM_OFS_STATUS, 32'h0);
        chk(rdat & 32'h1, 32'h0);
        wait_for(3 * HALF, 0, 1'b1);
        chk(32'(($time - t0) / 100), 32'(2 * HALF));
        xfer(1'b1, `TCPWM_OFS_MASK, 32'h0);
        xfer(1'b0, `TCPWM_OFS_STATUS, 32'h0);
        meas(3 * HALF);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b0, `TCPWM_OFS_STATUS, 32'h0);
        chk(rdat & 32'h1, 32'h1);
        // Full on: the staged value goes to temp at one trough and to compare at the next, within two carriers
        xfer(1'b1, `TCPWM_OFS_BUFFER, 32'h0);
        wait_for(8 * HALF, 1, 1'b0);
        meas(HALF);
        meas(2 * HALF);
        chk(pon, 2 * HALF);
        chk(non, 0);
        rd(`TCPWM_OFS_COMPARE, 32'h0);
        rd(`TCPWM_OFS_TEMP, 32'h0);
        xfer(1'b1, `TCPWM_OFS_BUFFER, 32'(HALF));
        wait_for(8 * HALF, 1, 1'b1);
        meas(HALF);
        meas(2 * HALF);
        chk(pon, 0);
        chk(non, 2 * HALF);
        xfer(1'b1, `TCPWM_OFS_CTRL, 32'h3);
        repeat (3) @(posedge mclk_i);
        chk({29'h0, pos_oe}, 32'h0);
        chk({26'h0, hs_on, ls_on}, 32'h0);
        chk({31'h0, fault}, 32'h0);
        end_of_test;
    end
endmodule // test_tcpwm_top

`default_nettype wire
